// ### lfs_supervisor.sv
// Purpose: Fault supervisor for a six channel boost LED driver
// Assumes: Comparator inputs are synchronous to ref_clk_i
// Notes:   Trip response is one clock (5 ns), well inside the 3 us budget
//          Trips while not yet enabled are ignored, so a noisy power-up cannot latch
//          The long-low clear takes 16 ms of clock; a short dimming gap never clears
`timescale 1ns/1ps
`include "lfs_consts.svh"
module lfs_supervisor (
  input  wire logic                     ref_clk_i,
  input  wire logic                     nrst_i,
  input  wire logic                     input_sense_trip_i,
  input  wire logic                     primary_current_limit_i,
  input  wire logic                     secondary_current_limit_i,
  input  wire logic                     above_rise_level_i,
  input  wire logic                     below_fall_level_i,
  input  wire logic                     enable_dim_i,
  input  wire logic [`LFS_CHANNELS-1:0] led_short_gnd_i,
  input  wire logic [`LFS_CHANNELS-1:0] led_in_reg_i,
  input  wire logic                     overvoltage_i,
  input  wire logic                     pwm_on_i,
  output logic                          boost_switch_node_o,
  output logic                          disconnect_gate_o,
  output logic [`LFS_CHANNELS-1:0]      led_sink_channel_o,
  output logic                          fault_n_o,
  output logic                          fault_oe_o
);

  lfs_pkg::lfs_state_s cur;
  lfs_pkg::lfs_state_s nxt;
  logic                latch_trip;
  logic                clear_req;
  logic                uv_event;
  logic                dim_rise;
  logic                any_short;
  logic [`LFS_CHANNELS-1:0] open_drop;

  // Fatal trips are taken raw so the off decision needs no extra stage
  assign latch_trip = input_sense_trip_i | secondary_current_limit_i;
  // Clear needs the full low count with the pin still low on the deciding edge
  assign clear_req  = (cur.low_cnt == `LFS_CLEAR_CW'(`LFS_CLEAR_CYCLES - 1)) && !enable_dim_i;
  // Input must still be low when the count is full, so the delay is strictly exceeded
  assign uv_event   = below_fall_level_i && cur.enabled
                      && (cur.uv_cnt == `LFS_UVLO_CW'(`LFS_UVLO_CYCLES));
  // Rising edge of enable/dim starts a fresh soft-start
  assign dim_rise   = enable_dim_i && !cur.dim_prev;
  assign any_short  = |led_short_gnd_i;
  // Only strings still out of regulation when overvoltage trips are dropped
  assign open_drop  = overvoltage_i ? ~led_in_reg_i & cur.sink_en : '0;

  // Next state of the whole supervisor. Flow: OFF waits for enable and a rising
  // enable/dim, START checks the LED pins once, SHORT_HOLD parks with the
  // disconnect on until the short goes, RUN regulates and drops open strings,
  // LATCHED holds everything off. Fatal trips and lockout override the case
  // below, in that order, so lockout always has the last word.
  // Trade-off: the short check is a single sample at start; a short that
  // appears later goes unseen until the next pass through START.
  always_comb begin
    nxt          = cur;
    nxt.dim_prev = enable_dim_i;
    // Glitch filter on the undervoltage fall comparator
    if (below_fall_level_i) begin
      if (cur.uv_cnt != `LFS_UVLO_CW'(`LFS_UVLO_CYCLES)) begin
        nxt.uv_cnt = cur.uv_cnt + `LFS_UVLO_CW'(1);
      end
    end else begin
      nxt.uv_cnt = '0;
    end
    // Cut holds until the modulator ends the on-time; a bare level gate would
    // fire the switch again as soon as the sensed current fell
    if (!pwm_on_i) begin
      nxt.on_cut = 1'b0;
    end else if (primary_current_limit_i) begin
      nxt.on_cut = 1'b1;
    end
    // Low-time counter for the latched fault clear
    if (enable_dim_i) begin
      nxt.low_cnt = '0;
    end else if (cur.low_cnt != `LFS_CLEAR_CW'(`LFS_CLEAR_CYCLES - 1)) begin
      nxt.low_cnt = cur.low_cnt + `LFS_CLEAR_CW'(1);
    end
    if (above_rise_level_i) begin
      nxt.enabled = 1'b1;
    end
    case (cur.state)
      lfs_pkg::LFS_OFF: begin
        nxt.boost_en  = 1'b0;
        nxt.disc_gate = 1'b0;
        nxt.sink_en   = '0;
        nxt.dropped   = '0;
        if (cur.enabled && dim_rise) begin
          nxt.state = lfs_pkg::LFS_START;
        end
      end
      lfs_pkg::LFS_START: begin
        // Short check only on entry to START, at dim rise or restart from SHORT_HOLD; masked later to avoid false trips
        nxt.disc_gate = 1'b1;
        if (any_short) begin
          nxt.state      = lfs_pkg::LFS_SHORT_HOLD;
          nxt.fault_flag = 1'b1;
          nxt.boost_en   = 1'b0;
          nxt.sink_en    = '0;
        end else begin
          nxt.state    = lfs_pkg::LFS_RUN;
          nxt.boost_en = 1'b1;
          nxt.sink_en  = {`LFS_CHANNELS{1'b1}};
        end
      end
      lfs_pkg::LFS_SHORT_HOLD: begin
        // Auto-restart once the short is gone
        nxt.boost_en  = 1'b0;
        nxt.sink_en   = '0;
        nxt.disc_gate = 1'b1;
        if (!any_short) begin
          nxt.fault_flag = cur.sticky_flag;
          nxt.state      = lfs_pkg::LFS_START;
        end
      end
      lfs_pkg::LFS_RUN: begin
        // Open strings are dropped at overvoltage, survivors keep regulating
        nxt.dropped = cur.dropped | open_drop;
        nxt.sink_en = ~(cur.dropped | open_drop);
        if (|open_drop) begin
          nxt.fault_flag  = 1'b1;
          nxt.sticky_flag = 1'b1;
        end
        if (!enable_dim_i && clear_req) begin
          nxt.state = lfs_pkg::LFS_OFF;
        end
      end
      lfs_pkg::LFS_LATCHED: begin
        // Stays off whatever the trip inputs do now
        // Only the long low or lockout gets out; a trip that has gone changes nothing
        nxt.boost_en   = 1'b0;
        nxt.disc_gate  = 1'b0;
        nxt.sink_en    = '0;
        nxt.fault_flag = 1'b1;
        if (clear_req) begin
          nxt.state       = lfs_pkg::LFS_OFF;
          nxt.fault_flag  = 1'b0;
          nxt.sticky_flag = 1'b0;
        end
      end
      default: begin
        nxt.state = lfs_pkg::LFS_OFF;
      end
    endcase
    // Long enable/dim low also clears the open-string flag; a drop in the same
    // cycle wins for that clock only, as the still-low pin clears it on the next
    if (clear_req && cur.state != lfs_pkg::LFS_SHORT_HOLD
        && !(cur.state == lfs_pkg::LFS_RUN && |open_drop)) begin
      nxt.fault_flag  = 1'b0;
      nxt.sticky_flag = 1'b0;
    end
    // Fatal trips win over all states, including startup
    if (latch_trip && cur.enabled) begin
      nxt.state      = lfs_pkg::LFS_LATCHED;
      nxt.boost_en   = 1'b0;
      nxt.disc_gate  = 1'b0;
      nxt.sink_en    = '0;
      nxt.fault_flag = 1'b1;
    end
    // Lockout clears every latched fault and raises no flag
    if (uv_event) begin
      nxt.enabled     = 1'b0;
      nxt.state       = lfs_pkg::LFS_OFF;
      nxt.boost_en    = 1'b0;
      nxt.disc_gate   = 1'b0;
      nxt.sink_en     = '0;
      nxt.dropped     = '0;
      nxt.fault_flag  = 1'b0;
      nxt.sticky_flag = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur          <= '0;
      cur.state    <= lfs_pkg::LFS_OFF;
    end else begin
      cur <= nxt;
    end
  end

  // Output flops; primary limit only cuts the present on-time
  // Outputs follow the next state so a trip reaches the pins on the edge that sees it
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      boost_switch_node_o <= 1'b0;
      disconnect_gate_o   <= 1'b0;
      led_sink_channel_o  <= '0;
      fault_n_o           <= 1'b1;
      fault_oe_o          <= 1'b0;
    end else begin
      boost_switch_node_o <= nxt.boost_en && pwm_on_i && !nxt.on_cut;
      disconnect_gate_o   <= nxt.disc_gate;
      led_sink_channel_o  <= nxt.sink_en;
      fault_n_o           <= 1'b0;           // Open drain: only low is ever driven
      fault_oe_o          <= nxt.fault_flag;
    end
  end

  // Checks on the supervisor outputs and state
  chk_trip_shutdown: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (latch_trip && cur.enabled && !uv_event) |=> (!boost_switch_node_o && !disconnect_gate_o
      && led_sink_channel_o == '0 && fault_oe_o))
    else $error("Trip did not shut down outputs");
  chk_latch_holds: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (cur.state == lfs_pkg::LFS_LATCHED && !clear_req && !uv_event) |=>
      (fault_oe_o && cur.state == lfs_pkg::LFS_LATCHED))
    else $error("Latched fault released early");
  chk_clear_latch: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (cur.state == lfs_pkg::LFS_LATCHED && clear_req && !latch_trip) |=>
      (cur.state == lfs_pkg::LFS_OFF && !fault_oe_o))
    else $error("Long low did not clear latch");
  chk_gate_drop: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (input_sense_trip_i && cur.enabled) |=> !disconnect_gate_o)
    else $error("Disconnect gate not dropped");
  chk_uv_filter: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (cur.enabled && !below_fall_level_i) |=> cur.enabled)
    else $error("Disabled without filtered undervoltage");
  chk_primary_limit: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (primary_current_limit_i && cur.state == lfs_pkg::LFS_RUN && !latch_trip && !uv_event
      && !clear_req && !overvoltage_i && !cur.fault_flag) |=>
      (!boost_switch_node_o && disconnect_gate_o && !fault_oe_o))
    else $error("Primary limit misbehaved");
  chk_short_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (cur.state == lfs_pkg::LFS_START && any_short && !latch_trip && !uv_event) |=>
      (fault_oe_o && disconnect_gate_o && !boost_switch_node_o && led_sink_channel_o == '0))
    else $error("Short at start not held");
  chk_open_drop: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (cur.state == lfs_pkg::LFS_RUN && |open_drop && !latch_trip && !uv_event && !clear_req)
      |=> (fault_oe_o && (led_sink_channel_o & $past(open_drop)) == '0))
    else $error("Open string not dropped");
  chk_uv_clear: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    uv_event |=> (!fault_oe_o && cur.state == lfs_pkg::LFS_OFF))
    else $error("Lockout did not clear faults");
  // Cut on-time stays cut after the current limit lets go
  chk_cut_holds: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (pwm_on_i && primary_current_limit_i) ##1 (pwm_on_i && !primary_current_limit_i)
      |=> !boost_switch_node_o)
    else $error("Cut on-time restarted early");
  // Secondary limit latches everything off
  chk_secondary_latch: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (secondary_current_limit_i && cur.enabled && !uv_event) |=>
      (cur.state == lfs_pkg::LFS_LATCHED && !boost_switch_node_o && !disconnect_gate_o
      && led_sink_channel_o == '0 && fault_oe_o))
    else $error("Secondary limit did not latch off");
  // Nothing moves until the rise level has been seen
  chk_idle_ignore: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!cur.enabled && !above_rise_level_i) |=> (cur.state == lfs_pkg::LFS_OFF && !fault_oe_o))
    else $error("Acted while not enabled");
  // Low-time counter steps by one on every low sample until full
  chk_clear_count: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!enable_dim_i && !clear_req) |=> (cur.low_cnt == $past(cur.low_cnt) + `LFS_CLEAR_CW'(1)))
    else $error("Low-time counter skipped");
  // A held short keeps the strings parked with the disconnect on
  chk_short_wait: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (cur.state == lfs_pkg::LFS_SHORT_HOLD && any_short && !latch_trip && !uv_event) |=>
      (fault_oe_o && disconnect_gate_o && !boost_switch_node_o && led_sink_channel_o == '0))
    else $error("Short hold released early");
  // A clean start opens the gate and every sink together
  chk_run_entry: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (cur.state == lfs_pkg::LFS_START && !any_short && !latch_trip && !uv_event) |=>
      (disconnect_gate_o && led_sink_channel_o == {`LFS_CHANNELS{1'b1}}))
    else $error("Clean start did not enable sinks");
  // Surviving strings keep regulating after a drop
  chk_open_keep: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (cur.state == lfs_pkg::LFS_RUN && |open_drop && !latch_trip && !uv_event && !clear_req)
      |=> (disconnect_gate_o && (led_sink_channel_o | $past(cur.dropped | open_drop)) == '1))
    else $error("Surviving strings were dropped");
  // A trip inside the start cycle still drops the gate and latches
  chk_trip_in_start: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (cur.state == lfs_pkg::LFS_START && input_sense_trip_i && !uv_event) |=>
      (cur.state == lfs_pkg::LFS_LATCHED && !disconnect_gate_o))
    else $error("Start trip not latched");
  // The fault pin only ever pulls low; release is left to the line pull-up
  chk_fault_data: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    1'b1 |=> !fault_n_o)
    else $error("Fault pin driven high");
  cov_latch: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    cur.state == lfs_pkg::LFS_LATCHED ##1 cur.state == lfs_pkg::LFS_OFF);
  cov_run: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    cur.state == lfs_pkg::LFS_START ##1 cur.state == lfs_pkg::LFS_RUN);
  cov_short: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    cur.state == lfs_pkg::LFS_SHORT_HOLD ##1 cur.state == lfs_pkg::LFS_START);
  cov_uv: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) uv_event);
  // Current limit released while the on-time request still stands
  cov_cut: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (pwm_on_i && primary_current_limit_i) ##1 (pwm_on_i && !primary_current_limit_i));

endmodule : lfs_supervisor

// ### lfs_consts.svh
// Purpose: Timing counts and channel count for the LED fault supervisor
// Assumes: 200 MHz supervisor clock
// Notes:   Counts are derived from times in their own unit
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH
`define LFS_CLK_MHZ        200
`define LFS_CHANNELS       6
`define LFS_UVLO_DLY_US    50
`define LFS_UVLO_CYCLES    (`LFS_UVLO_DLY_US * `LFS_CLK_MHZ)
`define LFS_CLEAR_DLY_MS   16
`define LFS_CLEAR_CYCLES   (`LFS_CLEAR_DLY_MS * 1000 * `LFS_CLK_MHZ)
`define LFS_UVLO_CW        14
`define LFS_CLEAR_CW       22
`endif

// ### lfs_pkg.sv
// Purpose: Types for the LED fault supervisor
// Assumes: Constants come from lfs_consts.svh
// Notes:   State of the supervisor is one packed struct
`include "lfs_consts.svh"
package lfs_pkg;
  typedef enum logic [2:0] {
    LFS_OFF,
    LFS_START,
    LFS_SHORT_HOLD,
    LFS_RUN,
    LFS_LATCHED
  } lfs_state_e;

  typedef struct packed {
    lfs_state_e                  state;
    logic [`LFS_UVLO_CW-1:0]     uv_cnt;
    logic [`LFS_CLEAR_CW-1:0]    low_cnt;
    logic                        enabled;
    logic                        boost_en;
    logic                        disc_gate;
    logic [`LFS_CHANNELS-1:0]    sink_en;
    logic [`LFS_CHANNELS-1:0]    dropped;
    logic                        fault_flag;
    logic                        sticky_flag;
    logic                        dim_prev;
    logic                        on_cut;
  } lfs_state_s;
endpackage : lfs_pkg

// ### lfs_ctrl_model.sv
// Purpose: System controller on the enable/dim pin and the shared fault line
// Assumes: Fault line has a pull-up; other devices on it stay released
// Notes:   Pin moves on falling edges only, so it never races the supervisor clock
`timescale 1ns/1ps
module lfs_ctrl_model (
  input  wire logic ref_clk_i,
  input  wire logic want_on_i,
  input  wire logic fault_oe_i,
  output logic      enable_dim_o,
  output logic      fault_line_o
);
  // Wired-AND line: an enabled driver pulls low, otherwise the pull-up wins
  assign fault_line_o = fault_oe_i ? 1'b0 : 1'b1;
  // Low periods are held as long as asked; a full clear needs the long count
  logic pend_on = 1'b0;
  initial enable_dim_o = 1'b0;
  // Request is taken on the rising edge and shown on the next falling edge,
  // so a request made at a falling edge never races the pin update
  always @(posedge ref_clk_i) begin
    pend_on <= want_on_i;
  end
  always @(negedge ref_clk_i) begin
    enable_dim_o <= pend_on;
  end
endmodule : lfs_ctrl_model

// ### test_lfs_supervisor.sv
// Purpose: Self-checking bench for the LED fault supervisor
// Assumes: Comparator inputs move on falling edges; pull-up on the fault line
// Notes:   The 16 ms clear is too long to run; lockout clears latches instead
`timescale 1ns/1ps
`include "lfs_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module test_lfs_supervisor;
  logic                     clk = 0, nrst = 0, trip = 0, prim = 0, sec = 0;
  logic                     rise = 0, fall = 0, ov = 0, pwm = 1, want = 0;
  logic [`LFS_CHANNELS-1:0] shrt = '0, inreg = '1, sinks;
  logic                     dim, boost, disc, fault_n, fault_oe, line;
  int                       n_errors = 0, num_checks = 0, cyc = 0;
  lfs_supervisor u_dut (.ref_clk_i(clk), .nrst_i(nrst), .input_sense_trip_i(trip),
    .primary_current_limit_i(prim), .secondary_current_limit_i(sec),
    .above_rise_level_i(rise), .below_fall_level_i(fall), .enable_dim_i(dim),
    .led_short_gnd_i(shrt), .led_in_reg_i(inreg), .overvoltage_i(ov), .pwm_on_i(pwm),
    .boost_switch_node_o(boost), .disconnect_gate_o(disc), .led_sink_channel_o(sinks),
    .fault_n_o(fault_n), .fault_oe_o(fault_oe));
  lfs_ctrl_model u_ctrl (.ref_clk_i(clk), .want_on_i(want), .fault_oe_i(fault_oe),
    .enable_dim_o(dim), .fault_line_o(line));
  // 200 MHz clock; a hang is cut short well past the expected run
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // Enable from lockout, then raise enable/dim and wait for the gate
  task bring_up(input logic [`LFS_CHANNELS-1:0] sh);
    int k;
    want = 0; shrt = sh; tick(3);
    rise = 1; tick(1); rise = 0; want = 1;
    k = 0;
    while (disc !== 1'b1 && k < 20) begin tick(1); k++; end
    tick(3);
  endtask : bring_up
  // Lockout: the full delay must not disable, one sample more must clear latches
  task lockout();
    fall = 1; tick(10000);
    `CHK(fault_oe, 1'b1)
    tick(1);
    `CHK(fault_oe, 1'b0)
    `CHK({boost, disc, sinks}, 8'h00)
    fall = 0; $display("done lockout");
  endtask : lockout
  task all_off(input logic oe);
    `CHK({boost, disc, sinks}, 8'h00)
    `CHK(fault_oe, oe)
    `CHK(line, ~oe)
    `CHK(fault_n, 1'b0)
  endtask : all_off
  task t_primary();
    bring_up('0);
    `CHK({boost, disc, sinks, fault_oe}, 9'h1fe)
    prim = 1; tick(2);
    `CHK({boost, disc, sinks, fault_oe}, 9'h0fe)
    prim = 0; tick(2);
    `CHK(boost, 1'b0)
    pwm = 0; tick(1); pwm = 1; tick(2);
    `CHK(boost, 1'b1)
    $display("done primary");
  endtask : t_primary
  task t_input_trip();
    trip = 1; tick(1); trip = 0; tick(1);
    all_off(1'b1);
    tick(50);
    all_off(1'b1);
    lockout(); $display("done input trip");
  endtask : t_input_trip
  task t_start_trip();
    want = 0; shrt = '0; tick(3);
    rise = 1; tick(1); rise = 0; want = 1;
    tick(2); trip = 1; tick(2); trip = 0;
    `CHK(disc, 1'b0)
    `CHK(fault_oe, 1'b1)
    lockout(); $display("done start trip");
  endtask : t_start_trip
  task t_secondary();
    bring_up('0);
    sec = 1; tick(2); sec = 0; tick(20);
    all_off(1'b1);
    want = 0; tick(200);
    all_off(1'b1);
    want = 1; tick(2);
    lockout(); $display("done secondary");
  endtask : t_secondary
  task t_short();
    bring_up(6'h04);
    `CHK({boost, disc, sinks, fault_oe}, 9'h081)
    shrt = '0; tick(6);
    `CHK({boost, disc, sinks, fault_oe}, 9'h1fe)
    $display("done short");
  endtask : t_short
  task t_open();
    inreg = 6'h3d; ov = 1; tick(3); ov = 0; inreg = '1; tick(3);
    `CHK(sinks, 6'h3d)
    `CHK({disc, fault_oe}, 2'h3)
    trip = 1; tick(2); trip = 0;
    `CHK(fault_oe, 1'b1)
    lockout(); $display("done open");
  endtask : t_open
  task report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    tick(8); nrst = 1; tick(1);
    t_primary();
    t_input_trip();
    t_start_trip();
    t_secondary();
    t_short();
    t_open();
    report_and_stop();
  end
endmodule : test_lfs_supervisor
